// [inc/psi_if.sv]
/*
 * Two-wire bus between host and device ends.
 * Resolves the open-drain wires from the drivers' enables; a line is
 * low while any enabled driver pulls it low, else high (pull-up).
 */
`timescale 1ns/1ps
`default_nettype none

interface psi_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // wired-and with pull-up
    assign scl = ~(scl_m_oe & ~scl_m_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

    modport host(output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
                 input scl, sda);
    modport dev(output sda_s_o, sda_s_oe, input scl, sda);
endinterface

`default_nettype wire

// [inc/psi_params.svh]
/*
 * Constants of the pressure sample two-wire port: timing, addresses,
 * count scaling. Assumes a 40 MHz system clock on both ends.
 */
`ifndef PSI_PARAMS_SVH
`define PSI_PARAMS_SVH

// system clock rate
`define PSI_CLK_MHZ 40
// conversion loop period, in ms
`define PSI_CONV_MS 0.5
`define PSI_CONV_CYC (int'(`PSI_CONV_MS * 1000.0 * `PSI_CLK_MHZ))
// bus clock rate made by the host, in kHz
`define PSI_SCL_KHZ 100
// one quarter of a bus clock period, in system clocks
`define PSI_QTR_CYC ((`PSI_CLK_MHZ * 1000) / (`PSI_SCL_KHZ * 4))

// slave addresses
`define PSI_OWN_ADDR 7'h28
`define PSI_ALT_ADDR 7'h78

// count scaling
`define PSI_SPAN 15'h6978
`define PSI_RANGE 16'h7FFF
`define PSI_OFS_DIFF 16'h4074
`define PSI_OFS_GAGE 16'h0BB8

// bit slots of one read: address 0..7, data 9..16 and 18..25
`define PSI_IDX_AACK 5'h08
`define PSI_IDX_MACK 5'h11
`define PSI_IDX_LAST 5'h1A

`endif

// [inc/psi_pkg.sv]
/*
 * Types of the pressure sample two-wire port.
 * Assumes psi_params.svh is compiled alongside.
 */
package psi_pkg;

    // device end states, gray along address, ack, send, master ack
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ADDR = 3'h1,
        S_AACK = 3'h3,
        S_SEND = 3'h2,
        S_MACK = 3'h6
    } psi_sst_t;

    // host end states
    typedef enum logic [1:0] {
        M_IDLE = 2'h0,
        M_START = 2'h1,
        M_BITS = 2'h3,
        M_STOP = 2'h2
    } psi_mst_t;

endpackage

// [rtl/psi_master.sv]
/*
 * Host end of the pressure sample two-wire port with its sample FIFO.
 * Makes the bus clock from clk by a divider and reads samples in a
 * stream, joined by repeated STARTs while the FIFO has room.
 */
`timescale 1ns/1ps
`default_nettype none
`include "psi_params.svh"

module psi_fifo #(
    parameter int W = 15,
    parameter int D = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp_r, rp_r;

    // extra pointer bit tells full from empty
    assign in_ready = (wp_r - rp_r) != (AW+1)'(D);
    assign out_valid = wp_r != rp_r;
    assign out_data = mem[rp_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule

module psi_master #(
    parameter int QTR_CYC = `PSI_QTR_CYC,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // two-wire bus
    psi_if.host bus,
    // user control
    input wire logic run,
    input wire logic [6:0] dev_addr,
    output logic addr_nack,
    // sample stream
    output logic smp_valid,
    input wire logic smp_ready,
    output logic [14:0] smp_data
);
    import psi_pkg::*;

    localparam int QW = $clog2(QTR_CYC + 1);
    localparam logic [QW-1:0] QTR_LAST = QW'(QTR_CYC - 1);

    logic [QW-1:0] qc_r;
    logic qtick;
    logic [1:0] q_r;
    psi_mst_t st_r;
    logic [4:0] idx_r;
    logic [4:0] idx_nx;
    logic [7:0] adr_r;
    logic [15:0] rx_r;
    logic nak_r;
    logic push_r;
    logic scl_oe_r, sda_oe_r;
    logic sda_s1, sda_s2;
    logic room;
    logic drv_nx;

    // quarter-period divider for the bus clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            qc_r <= '0;
        end else if (qc_r == QTR_LAST) begin
            qc_r <= '0;
        end else begin
            qc_r <= qc_r + 1'b1;
        end
    end
    assign qtick = (qc_r == QTR_LAST);

    // data pin synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
        end
    end

    // pull-low enable wanted in the next bit slot: address, ack of byte one
    always_comb begin
        idx_nx = idx_r + 5'h01;
        if (idx_nx < `PSI_IDX_AACK) begin
            drv_nx = ~adr_r[3'(7 - idx_nx)];
        end else begin
            drv_nx = (idx_nx == `PSI_IDX_MACK);
        end
    end

    // bus sequencer, acts at each quarter boundary
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q_r <= 2'h0;
            st_r <= M_IDLE;
            idx_r <= 5'h00;
            adr_r <= 8'h00;
            rx_r <= 16'h0000;
            nak_r <= 1'b0;
            push_r <= 1'b0;
            addr_nack <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            push_r <= 1'b0;
            addr_nack <= 1'b0;
            if (qtick) begin
                q_r <= q_r + 2'h1;
                case (q_r)
                    2'h0: begin
                        if (st_r != M_IDLE) begin
                            scl_oe_r <= 1'b0;
                        end
                    end
                    2'h1: begin
                        if (st_r == M_START) begin
                            sda_oe_r <= 1'b1;
                        end else if (st_r == M_STOP) begin
                            sda_oe_r <= 1'b0;
                        end else if (st_r == M_BITS) begin
                            if (idx_r == `PSI_IDX_AACK) begin
                                nak_r <= sda_s2;
                            end else if (idx_r > `PSI_IDX_AACK
                                && idx_r != `PSI_IDX_MACK
                                && idx_r != `PSI_IDX_LAST) begin
                                // data bits only, ack slots stay out
                                rx_r <= {rx_r[14:0], sda_s2};
                            end
                        end
                    end
                    2'h2: begin
                        if (st_r == M_START || st_r == M_BITS) begin
                            scl_oe_r <= 1'b1;
                        end
                    end
                    default: begin
                        case (st_r)
                            M_IDLE: begin
                                if (run && room) begin
                                    adr_r <= {dev_addr, 1'b1};
                                    st_r <= M_START;
                                end
                            end
                            M_START: begin
                                idx_r <= 5'h00;
                                sda_oe_r <= ~adr_r[7];
                                st_r <= M_BITS;
                            end
                            M_BITS: begin
                                if (idx_r == `PSI_IDX_AACK && nak_r) begin
                                    addr_nack <= 1'b1;
                                    sda_oe_r <= 1'b1;
                                    st_r <= M_STOP;
                                end else if (idx_r == `PSI_IDX_LAST) begin
                                    if (run && room) begin
                                        // repeated start, no stop between
                                        sda_oe_r <= 1'b0;
                                        st_r <= M_START;
                                    end else begin
                                        sda_oe_r <= 1'b1;
                                        st_r <= M_STOP;
                                    end
                                end else begin
                                    // last data bit is in: store it
                                    push_r <= (idx_nx == `PSI_IDX_LAST);
                                    idx_r <= idx_nx;
                                    sda_oe_r <= drv_nx;
                                end
                            end
                            default: begin
                                st_r <= M_IDLE;
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    // a read stores its word one slot before the next read is decided,
    // so room already counts it and a started read always fits
    logic in_ready;
    assign room = in_ready && !push_r;

    psi_fifo #(.W(15), .D(DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(push_r),
        .in_ready(in_ready),
        .in_data(rx_r[14:0]),
        .out_valid(smp_valid),
        .out_ready(smp_ready),
        .out_data(smp_data)
    );

    assign bus.scl_m_o = 1'b0;
    assign bus.scl_m_oe = scl_oe_r;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = sda_oe_r;
endmodule

`default_nettype wire

// [rtl/psi_slave.sv]
/*
 * Device end of the pressure sample two-wire port: conversion loop
 * with count scaling on clk, bus slave on the link sampling clock.
 * Assumes a host that makes the bus clock, START and STOP, and a
 * link clock at least eight times the bus clock.
 */
// Summary of operation
// - refresh held pressure result every 0.5 ms
// - pure slave, never drives clock
// - both lines released while idle
// - falling data, clock high means START
// - rising data, clock high means STOP
// - repeated START begins a fresh read
// - data changes only while clock low
// - answer own address and 0x78
// - address byte: seven bits then direction
// - read returns two bytes of result
// - span scaled to 27000 counts
// - zero offset 16500 differential, 3000 gage
// - result saturates at 32767 counts
`timescale 1ns/1ps
`default_nettype none
`include "psi_params.svh"

module psi_slave #(
    parameter logic [6:0] OWN_ADDR = `PSI_OWN_ADDR,
    parameter int CONV_CYC = `PSI_CONV_CYC
) (
    // system clock domain
    input wire logic clk,
    input wire logic rstn,
    // link sampling clock domain
    input wire logic lclk,
    // two-wire bus
    psi_if.dev bus,
    // sensing element side
    input wire logic [15:0] raw_code,
    input wire logic gage_mode,
    output logic [14:0] sample_value,
    output logic sample_stb
);
    import psi_pkg::*;

    localparam int CW = $clog2(CONV_CYC);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);

    logic [CW-1:0] conv_cnt_r;
    logic [14:0] hold_r;
    logic tgl_r;
    logic [15:0] raw_x;
    logic [30:0] prod;
    logic [15:0] scaled;
    logic [14:0] hold_nxt;

    // scale raw fraction onto span, add offset, clip at range;
    // differential raw is signed about zero pressure, so its sign bit
    // is flipped to offset binary and one unsigned product serves both
    always_comb begin
        raw_x = gage_mode ? raw_code : {~raw_code[15], raw_code[14:0]};
        prod = 31'(raw_x) * 31'(`PSI_SPAN);
        scaled = 16'(prod[30:16]) + (gage_mode ? `PSI_OFS_GAGE
            : `PSI_OFS_DIFF - 16'(`PSI_SPAN >> 1));
        if (scaled > `PSI_RANGE) begin
            hold_nxt = 15'h7FFF;
        end else begin
            hold_nxt = scaled[14:0];
        end
    end

    // conversion loop runs free of bus traffic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_cnt_r <= '0;
        end else if (conv_cnt_r == CONV_LAST) begin
            conv_cnt_r <= '0;
        end else begin
            conv_cnt_r <= conv_cnt_r + 1'b1;
        end
    end

    // holding register, toggle tells the link side it moved
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_r <= 15'h0000;
            tgl_r <= 1'b0;
            sample_stb <= 1'b0;
        end else begin
            sample_stb <= 1'b0;
            if (conv_cnt_r == CONV_LAST) begin
                hold_r <= hold_nxt;
                tgl_r <= ~tgl_r;
                sample_stb <= 1'b1;
            end
        end
    end

    assign sample_value = hold_r;

    // link side: synchronisers for pins and toggle
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic tg_s1, tg_s2, tg_d;
    logic [14:0] cur_r;

    always_ff @(posedge lclk or negedge rstn) begin
        if (!rstn) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= bus.scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= bus.sda;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    // word crossing: hold_r changes with each toggle and then stays stable
    // for a whole loop period, so it is safe to copy once it is seen
    always_ff @(posedge lclk or negedge rstn) begin
        if (!rstn) begin
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
            tg_d <= 1'b0;
            cur_r <= 15'h0000;
        end else begin
            tg_s1 <= tgl_r;
            tg_s2 <= tg_s1;
            tg_d <= tg_s2;
            if (tg_s2 != tg_d) begin
                cur_r <= hold_r;
            end
        end
    end

    // bus events from the synchronised, delayed copies
    logic rise, fall, start_ev, stop_ev;
    assign rise = scl_s2 & ~scl_d;
    assign fall = ~scl_s2 & scl_d;
    assign start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;

    psi_sst_t st_r;
    logic [2:0] cnt_r;
    logic full_r;
    logic [7:0] sr_r;
    logic rw_r;
    logic [15:0] tx_r;
    logic byte_r;
    logic mack_r;
    logic oe_r;
    logic hit;

    assign hit = (sr_r[7:1] == OWN_ADDR)
        || (sr_r[7:1] == `PSI_ALT_ADDR);

    // slave sequencer; only pulls data low, never touches the clock
    always_ff @(posedge lclk or negedge rstn) begin
        if (!rstn) begin
            st_r <= S_IDLE;
            cnt_r <= 3'h0;
            full_r <= 1'b0;
            sr_r <= 8'h00;
            rw_r <= 1'b0;
            tx_r <= 16'h0000;
            byte_r <= 1'b0;
            mack_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (stop_ev) begin
            st_r <= S_IDLE;
            oe_r <= 1'b0;
        end else if (start_ev) begin
            st_r <= S_ADDR;
            cnt_r <= 3'h0;
            full_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            case (st_r)
                S_IDLE: begin
                    oe_r <= 1'b0;
                end
                S_ADDR: begin
                    if (rise) begin
                        sr_r <= {sr_r[6:0], sda_s2};
                        cnt_r <= cnt_r + 3'h1;
                        full_r <= (cnt_r == 3'h7);
                    end else if (fall && full_r) begin
                        full_r <= 1'b0;
                        rw_r <= sr_r[0];
                        if (hit) begin
                            oe_r <= 1'b1;
                            st_r <= S_AACK;
                        end else begin
                            st_r <= S_IDLE;
                        end
                    end
                end
                S_AACK: begin
                    if (fall) begin
                        cnt_r <= 3'h0;
                        byte_r <= 1'b0;
                        if (rw_r) begin
                            tx_r <= {1'b0, cur_r};
                            oe_r <= 1'b1;
                            st_r <= S_SEND;
                        end else begin
                            // writes are acked and then ignored
                            oe_r <= 1'b0;
                            st_r <= S_IDLE;
                        end
                    end
                end
                S_SEND: begin
                    if (rise) begin
                        cnt_r <= cnt_r + 3'h1;
                        full_r <= (cnt_r == 3'h7);
                    end else if (fall) begin
                        if (full_r) begin
                            full_r <= 1'b0;
                            oe_r <= 1'b0;
                            st_r <= S_MACK;
                        end else begin
                            tx_r <= {tx_r[14:0], 1'b0};
                            oe_r <= ~tx_r[14];
                        end
                    end
                end
                S_MACK: begin
                    if (rise) begin
                        mack_r <= ~sda_s2;
                    end else if (fall) begin
                        if (mack_r && !byte_r) begin
                            byte_r <= 1'b1;
                            tx_r <= {tx_r[14:0], 1'b0};
                            oe_r <= ~tx_r[14];
                            st_r <= S_SEND;
                        end else begin
                            // nack or second byte done: let go
                            oe_r <= 1'b0;
                            st_r <= S_IDLE;
                        end
                    end
                end
                default: begin
                    oe_r <= 1'b0;
                    st_r <= S_IDLE;
                end
            endcase
        end
    end

    // open drain: output level fixed low, enable pulls
    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = oe_r;
endmodule

`default_nettype wire

// [test/pressure_sample_i2c_slave_tb.sv]
/*
 * Bench joining host and device ends over one bus interface.
 * Assumes clk 25 ns, link clock 80 ns, shortened loop and quarter.
 */
`timescale 1ns/1ps
`default_nettype none
`include "psi_params.svh"

module pressure_sample_i2c_slave_tb;
    localparam int CONV = 200;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] raw_code = 16'h0000;
    logic gage_mode = 1'b0;
    logic [14:0] sample_value;
    logic sample_stb;
    logic run = 1'b0;
    logic [6:0] dev_addr = `PSI_OWN_ADDR;
    logic addr_nack;
    logic smp_valid;
    logic smp_ready = 1'b0;
    logic [14:0] smp_data;
    int errors = 0;
    int n_compared = 0;
    int cnt;

    psi_if bus_if();
    psi_slave #(.OWN_ADDR(`PSI_OWN_ADDR), .CONV_CYC(CONV)) u_psi_slave (
        .clk(clk), .rstn(rstn), .lclk(lclk), .bus(bus_if),
        .raw_code(raw_code), .gage_mode(gage_mode),
        .sample_value(sample_value), .sample_stb(sample_stb));
    psi_master #(.QTR_CYC(20), .DEPTH(16)) u_psi_master (
        .clk(clk), .rstn(rstn), .bus(bus_if), .run(run),
        .dev_addr(dev_addr), .addr_nack(addr_nack), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_data(smp_data));
    psi_properties #(.OWN_ADDR(`PSI_OWN_ADDR)) u_psi_properties (
        .clk(clk), .rstn(rstn), .scl_m_o(bus_if.scl_m_o),
        .scl_m_oe(bus_if.scl_m_oe), .sda_m_o(bus_if.sda_m_o),
        .sda_m_oe(bus_if.sda_m_oe), .sda_s_o(bus_if.sda_s_o),
        .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda));

    // two unrelated clocks
    always #12.5 clk = ~clk;
    always #40 lclk = ~lclk;

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // bounded wait, n reaches lim when it ran out
    task automatic wait_hi(ref logic sig, input int lim, output int n);
        n = 0;
        #1;
        while (sig !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic must(input int n, input int lim);
        if (n >= lim) begin
            check("wait bound", 32'h0, 32'h1);
            finish_test();
        end
    endtask

    // scaled count; differential raw is signed about zero pressure
    function automatic logic [14:0] expv(input logic [15:0] raw,
                                         input logic g);
        logic [31:0] v;
        v = ((32'(g ? raw : raw ^ 16'h8000) * 32'h6978) >> 16)
            + (g ? 32'hBB8 : 32'h4074 - 32'h34BC);
        return (v > 32'h7FFF) ? 15'h7FFF : v[14:0];
    endfunction

    // pop every word that arrives, gap of 3000 cycles ends it
    task automatic drain(input logic [14:0] exp, output int c);
        int n;
        c = 0;
        n = 0;
        while (n < 3000) begin
            wait_hi(smp_valid, 3000, n);
            if (n < 3000) begin
                check("smp_data", smp_data, exp);
                @(posedge clk);
                smp_ready <= 1'b1;
                @(posedge clk);
                smp_ready <= 1'b0;
                c++;
            end
        end
    endtask

    // loop period and scaling at both ends of the raw range
    task automatic t_conv();
        int n;
        for (int k = 0; k < 4; k++) begin
            wait_hi(sample_stb, 2 * CONV, n);
            must(n, 2 * CONV);
            @(posedge clk);
            raw_code <= k[0] ? 16'hFFFF : 16'h0000;
            gage_mode <= k[1];
            wait_hi(sample_stb, 2 * CONV, n);
            must(n, 2 * CONV);
            check("period", n + 1, CONV);
            check("sample", sample_value, expv(raw_code, gage_mode));
        end
    endtask

    // refresh the held value with new inputs before a read
    task automatic settle(input logic [15:0] r, input logic g);
        int n;
        @(posedge clk);
        raw_code <= r;
        gage_mode <= g;
        wait_hi(sample_stb, 2 * CONV, n);
        @(posedge clk);
        wait_hi(sample_stb, 2 * CONV, n);
        must(n, 2 * CONV);
    endtask

    // unknown address is refused and nothing is stored
    task automatic t_nack();
        int n;
        @(posedge clk);
        dev_addr <= 7'h11;
        run <= 1'b1;
        wait_hi(addr_nack, 4000, n);
        must(n, 4000);
        @(posedge clk);
        run <= 1'b0;
        drain(15'h0000, cnt);
        check("nack words", cnt, 0);
    endtask

    // fill the buffer by back-to-back reads with drain stalled
    task automatic t_fill();
        int n;
        int i;
        settle(16'hC2A5, 1'b1);
        @(posedge clk);
        dev_addr <= `PSI_OWN_ADDR;
        run <= 1'b1;
        n = 0;
        i = 0;
        while (n < 3000 && i < 60000) begin
            @(posedge clk);
            n = (bus_if.scl && bus_if.sda) ? n + 1 : 0;
            i++;
        end
        must(i, 60000);
        @(posedge clk);
        run <= 1'b0;
        drain(expv(16'hC2A5, 1'b1), cnt);
        check("fill words", cnt, 16);
    endtask

    // the fixed second address answers as well
    task automatic t_alt();
        int n;
        settle(16'h1234, 1'b0);
        @(posedge clk);
        dev_addr <= `PSI_ALT_ADDR;
        run <= 1'b1;
        wait_hi(smp_valid, 4000, n);
        must(n, 4000);
        @(posedge clk);
        run <= 1'b0;
        drain(expv(16'h1234, 1'b0), cnt);
        check("alt read", cnt != 0, 1);
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_conv();
        t_nack();
        t_fill();
        t_alt();
        finish_test();
    end
endmodule

`default_nettype wire

// [test/psi_properties.sv]
/*
 * Bus checker for the two-wire link between host and device ends.
 * Assumes the interface signals as inputs, sampled on clk, and a host
 * quarter period of at least 16 clk cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "psi_params.svh"

module psi_properties #(
    parameter logic [6:0] OWN_ADDR = 7'h28
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // drivers and resolved lines
    input wire logic scl_m_o,
    input wire logic scl_m_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_d_r;
    logic sda_d_r;
    logic busy_r;
    logic acked_r;
    logic [4:0] bc_r;
    logic [7:0] sh_r;
    wire logic start_w = scl & scl_d_r & sda_d_r & ~sda;
    wire logic stop_w = scl & scl_d_r & ~sda_d_r & sda;
    wire logic rise_w = scl & ~scl_d_r;
    wire logic adr_ok_w = (sh_r[7:1] == OWN_ADDR) ||
                          (sh_r[7:1] == `PSI_ALT_ADDR);

    // line history, reset high like the pull-ups
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl;
            sda_d_r <= sda;
        end
    end
    // transfer open between START and STOP
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_r <= 1'b0;
        end else if (start_w || stop_w) begin
            busy_r <= start_w;
        end
    end
    // bit slot count, saturates so stray pulses never wrap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bc_r <= 5'h1F;
        end else if (start_w) begin
            bc_r <= 5'h00;
        end else if (rise_w && bc_r != 5'h1F) begin
            bc_r <= bc_r + 5'h01;
        end
    end
    // address byte as seen on the wire
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sh_r <= 8'h00;
        end else if (rise_w && bc_r < 5'h08) begin
            sh_r <= {sh_r[6:0], sda};
        end
    end
    // read acknowledged by the device
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acked_r <= 1'b0;
        end else if (start_w) begin
            acked_r <= 1'b0;
        end else if (rise_w && bc_r == 5'h08) begin
            acked_r <= ~sda & sh_r[0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_scl_high8;
        scl [*8];
    endsequence
    sequence s_host_free8;
        (!sda_m_oe && !scl_m_oe) [*8];
    endsequence

    a_idle_lines_free: assert property (!busy_r && !start_w |->
        !sda_m_oe && !scl_m_oe && !sda_s_oe) else $error("line held idle");
    a_dev_changes_low: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("device data moved with clock high");
    a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    a_start_hold: assert property (start_w |-> s_scl_high8)
        else $error("clock fell too soon after start");
    a_stop_bus_free: assert property (stop_w |=> s_host_free8)
        else $error("host drove bus right after stop");
    a_addr_ack_match: assert property (rise_w && bc_r == 5'h08 |->
        sda_s_oe == adr_ok_w) else $error("address ack wrong");
    a_first_bit_zero: assert property (rise_w && bc_r == 5'h09 &&
        acked_r |-> !sda && sda_s_oe) else $error("top data bit not zero");
    a_host_mid_ack: assert property (rise_w && bc_r == 5'h11 &&
        acked_r |-> sda_m_oe && !sda) else $error("first byte not acked");
    a_host_last_nack: assert property (rise_w && bc_r == 5'h1A &&
        acked_r |-> sda && !sda_s_oe) else $error("last byte not nacked");
    a_no_mid_frame: assert property ((start_w || stop_w) && acked_r |->
        bc_r >= 5'h1B) else $error("start or stop inside a read");
endmodule

`default_nettype wire
